//--- hdl/dps_pkg.sv
package dps_pkg;
	// geometry of one memory block
	localparam int DPS_TOTAL_BITS = 256;
	localparam int DPS_BYTE_W = 8;
	localparam int DPS_NIB_W = 4;
	localparam int DPS_WORDS = DPS_TOTAL_BITS / DPS_BYTE_W;
	localparam int DPS_LANES = DPS_BYTE_W / DPS_NIB_W;
	localparam int DPS_ADDR_W = 6;
	localparam int DPS_ROW_W = DPS_ADDR_W - 1;
	// position of the address bit that picks the nibble lane
	localparam int DPS_LANE_BIT = 5;
	// values after reset
	localparam logic [DPS_BYTE_W-1:0] DPS_RD_DATA_RST = 8'h00;
	localparam logic DPS_CLK_SAMPLE_RST = 1'b0;
	localparam logic DPS_PRIMED_RST = 1'b0;
	// lane enables for whole byte and for each nibble
	localparam logic [DPS_LANES-1:0] DPS_LANES_ALL = 2'h3;
	localparam logic [DPS_LANES-1:0] DPS_LANE_LO = 2'h1;
	localparam logic [DPS_LANES-1:0] DPS_LANE_HI = 2'h2;
	localparam logic [DPS_NIB_W-1:0] DPS_NIB_ZERO = 4'h0;
endpackage : dps_pkg

//--- hdl/dps_sram_block.sv
`timescale 1ns/1ps
`default_nettype none
module dps_sram_block (
	input wire logic clock,
	input wire logic rst,
	input wire logic byte_mode,
	input wire logic read_async,
	input wire logic write_clk,
	input wire logic write_edge_fall,
	input wire logic write_en,
	input wire logic [dps_pkg::DPS_ADDR_W-1:0] write_word_select,
	input wire logic [dps_pkg::DPS_BYTE_W-1:0] write_data_in,
	input wire logic read_clk,
	input wire logic read_edge_fall,
	input wire logic [dps_pkg::DPS_ADDR_W-1:0] read_word_select,
	output logic [dps_pkg::DPS_BYTE_W-1:0] read_data
);
	import dps_pkg::*;

	logic write_clk_q;
	logic read_clk_q;
	logic primed_q;
	logic [DPS_BYTE_W-1:0] read_data_q;
	logic [DPS_BYTE_W-1:0] read_data_d;

	wire write_rise;
	wire write_fall;
	wire read_rise;
	wire read_fall;
	wire write_stb;
	wire read_stb;
	wire [DPS_ROW_W-1:0] write_row;
	wire [DPS_ROW_W-1:0] read_row;
	wire write_lane;
	wire read_lane;
	wire [DPS_LANES-1:0] write_lanes;
	wire [DPS_BYTE_W-1:0] write_word;
	wire [DPS_BYTE_W-1:0] stored_word;
	wire [DPS_NIB_W-1:0] stored_nib;
	wire [DPS_BYTE_W-1:0] selected_word;
	wire [DPS_WORDS*DPS_BYTE_W-1:0] contents;

	// port clocks are plain synchronous inputs; edges come from the last sample
	assign write_rise = write_clk & ~write_clk_q;
	assign write_fall = ~write_clk & write_clk_q;
	assign read_rise = read_clk & ~read_clk_q;
	assign read_fall = ~read_clk & read_clk_q;

	// active edge picked per port; first cycle after reset is masked
	// so a port clock already high at release is not taken for an edge
	assign write_stb = primed_q & write_en
		& (write_edge_fall ? write_fall : write_rise);
	assign read_stb = primed_q
		& (read_edge_fall ? read_fall : read_rise);

	// row is the low five bits; bit five only picks a nibble lane
	assign write_row = write_word_select[DPS_ROW_W-1:0];
	assign read_row = read_word_select[DPS_ROW_W-1:0];
	assign write_lane = write_word_select[DPS_LANE_BIT];
	assign read_lane = read_word_select[DPS_LANE_BIT];

	// byte mode writes both lanes, 64x4 mode one lane by bit five
	assign write_lanes = byte_mode ? DPS_LANES_ALL
		: (write_lane ? DPS_LANE_HI : DPS_LANE_LO);
	// nibble data is copied to both lanes, the lane enable picks one
	assign write_word = byte_mode ? write_data_in
		: {write_data_in[DPS_NIB_W-1:0], write_data_in[DPS_NIB_W-1:0]};

	// read selection: whole byte, or the chosen nibble zero-extended
	assign stored_nib = read_lane ? stored_word[DPS_BYTE_W-1:DPS_NIB_W]
		: stored_word[DPS_NIB_W-1:0];
	assign selected_word = byte_mode ? stored_word
		: {DPS_NIB_ZERO, stored_nib};

	// sync mode reloads only on the read edge, otherwise holds
	assign read_data_d = read_stb ? selected_word : read_data_q;
	// async mode bypasses the register entirely
	assign read_data = read_async ? selected_word : read_data_q;

	// ports share only the array, so a read never waits on a write;
	// a read of the row being written in the same cycle sees old data
	dps_store #(
		.WORDS(DPS_WORDS),
		.WIDTH(DPS_BYTE_W),
		.LANES(DPS_LANES),
		.ROW_W(DPS_ROW_W)
	) u_store (
		.clock(clock),
		.wr_en(write_stb),
		.wr_row(write_row),
		.wr_lane_en(write_lanes),
		.wr_data(write_word),
		.rd_row(read_row),
		.rd_word(stored_word),
		.contents(contents)
	);

	// clock samples and edge mask
	always_ff @(posedge clock) begin
		if (rst) begin
			write_clk_q <= DPS_CLK_SAMPLE_RST;
			read_clk_q <= DPS_CLK_SAMPLE_RST;
			primed_q <= DPS_PRIMED_RST;
		end else begin
			write_clk_q <= write_clk;
			read_clk_q <= read_clk;
			primed_q <= 1'b1;
		end
	end

	// read data register for synchronous reads
	always_ff @(posedge clock) begin
		if (rst) begin
			read_data_q <= DPS_RD_DATA_RST;
		end else begin
			read_data_q <= read_data_d;
		end
	end

	// cascading: nothing here is shared between blocks, so a wider memory
	// ties addresses of several blocks together and a deeper one gates
	// write_en and picks read_data from a decode of upper address bits

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	// a write lands in the addressed row one cycle later
	a_write_byte_lands: assert property (
		write_stb && byte_mode
		|=> contents[{$past(write_row), 3'b000} +: DPS_BYTE_W]
			== $past(write_data_in)
	) else $error("byte write not stored in addressed row");

	// no strobe, no change anywhere in the array
	a_idle_no_write: assert property (
		!write_stb |=> contents === $past(contents)
	) else $error("array changed without a write strobe");

	// nibble write touches only its own lane
	a_nibble_lane_only: assert property (
		write_stb && !byte_mode
		|=> contents[{$past(write_row), ~$past(write_lane), 2'b00} +: DPS_NIB_W]
			=== $past(contents[{write_row, ~write_lane, 2'b00} +: DPS_NIB_W])
			&& contents[{$past(write_row), $past(write_lane), 2'b00}
				+: DPS_NIB_W] == $past(write_data_in[DPS_NIB_W-1:0])
	) else $error("nibble write disturbed or missed its lane");

	// in byte mode the top address bit makes no difference
	a_byte_msb_ignored: assert property (
		read_async && byte_mode
		|-> read_data == contents[{read_word_select[DPS_ROW_W-1:0], 3'b000}
			+: DPS_BYTE_W]
	) else $error("byte read depends on address bit five");

	// strobe only on the selected edge of the port clock
	a_write_edge_sel: assert property (
		write_stb |-> write_en && (write_edge_fall
			? (!write_clk && $past(write_clk))
			: (write_clk && !$past(write_clk)))
	) else $error("write strobe on the wrong clock edge");

	a_read_edge_sel: assert property (
		read_stb |-> (read_edge_fall
			? (!read_clk && $past(read_clk))
			: (read_clk && !$past(read_clk)))
	) else $error("read strobe on the wrong clock edge");

	// synchronous read shows the word that stood at the edge
	a_sync_read_load: assert property (
		read_stb && !read_async && byte_mode && $past(!rst)
		##1 !read_async
		|-> read_data == $past(contents[{read_row, 3'b000} +: DPS_BYTE_W])
	) else $error("sync read did not load the addressed word");

	// between read edges the synchronous output stands
	a_sync_read_hold: assert property (
		!read_async && !read_stb ##1 !read_async
		|-> $stable(read_data)
	) else $error("sync read output moved without a read edge");

	// 64x4 mode: upper half zero, lower half the chosen nibble
	a_nibble_read_sel: assert property (
		read_async && !byte_mode
		|-> read_data[DPS_BYTE_W-1:DPS_NIB_W] == DPS_NIB_ZERO
			&& read_data[DPS_NIB_W-1:0]
				== contents[{read_row, read_lane, 2'b00} +: DPS_NIB_W]
	) else $error("nibble read returned the wrong lane");

	// a read beside a write still returns the old word
	a_ports_concurrent: assert property (
		write_stb && read_stb && byte_mode && !read_async ##1 !read_async
		|-> read_data == $past(contents[{read_row, 3'b000} +: DPS_BYTE_W])
	) else $error("read port held up by concurrent write");

	// reset clears the sync read register whatever the port clocks do;
	// the default disable is lifted here since reset is the antecedent
	a_reset_read_clear: assert property (
		disable iff (1'b0) rst |=> read_data_q == DPS_RD_DATA_RST
	) else $error("read register not cleared by reset");

	c_byte_write: cover property (write_stb && byte_mode);
	c_nibble_write_hi: cover property (write_stb && !byte_mode && write_lane);
	c_sync_read: cover property (read_stb && !read_async);
	c_async_read: cover property (read_async && !byte_mode);
	c_same_cycle: cover property (write_stb && read_stb);
endmodule : dps_sram_block
`default_nettype wire

//--- hdl/dps_store.sv
`timescale 1ns/1ps
`default_nettype none
module dps_store #(
	parameter int WORDS = 32,
	parameter int WIDTH = 8,
	parameter int LANES = 2,
	parameter int ROW_W = 5
) (
	input wire logic clock,
	input wire logic wr_en,
	input wire logic [ROW_W-1:0] wr_row,
	input wire logic [LANES-1:0] wr_lane_en,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic [ROW_W-1:0] rd_row,
	output logic [WIDTH-1:0] rd_word,
	output logic [WORDS*WIDTH-1:0] contents
);
	localparam int LANE_W = WIDTH / LANES;

	logic [WIDTH-1:0] mem_q [WORDS];
	logic [WORDS-1:0] row_hit;

	// one-hot row decode, empty when no write is in progress
	assign row_hit = wr_en ? (WORDS'(1) << wr_row) : '0;
	// read path is pure selection so async reads see it directly
	assign rd_word = mem_q[rd_row];

	// storage has no reset: contents are undefined until written
	for (genvar i = 0; i < WORDS; i++) begin : g_row
		assign contents[i*WIDTH +: WIDTH] = mem_q[i];
		for (genvar j = 0; j < LANES; j++) begin : g_lane
			always_ff @(posedge clock) begin
				if (row_hit[i] && wr_lane_en[j]) begin
					mem_q[i][j*LANE_W +: LANE_W] <= wr_data[j*LANE_W +: LANE_W];
				end
			end
		end
	end
endmodule : dps_store
`default_nettype wire

//--- testbench/dps_fabric.sv
`timescale 1ns/1ps
`default_nettype none
// fabric-side driver of both port clocks
module dps_fabric (
	input wire logic clock,
	input wire logic write_edge_fall,
	input wire logic read_edge_fall,
	output wire logic write_clk,
	output wire logic read_clk
);
	logic w_act = 1'b0;
	logic r_act = 1'b0;
	// rest level follows the polarity, so idle never looks active
	assign write_clk = write_edge_fall ^ w_act;
	assign read_clk = read_edge_fall ^ r_act;
	// each level held two cycles: slower than clock/2
	task automatic strobe(input logic w, input logic r);
		w_act = w;
		r_act = r;
		repeat (2) @(posedge clock);
		#1;
		w_act = 1'b0;
		r_act = 1'b0;
		repeat (2) @(posedge clock);
		#1;
	endtask : strobe
endmodule : dps_fabric
`default_nettype wire

//--- testbench/dps_sram_block_bench.sv
`timescale 1ns/1ps
`default_nettype none
module dps_sram_block_bench;
	import dps_pkg::*;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic byte_mode = 1'b0;
	logic read_async = 1'b0;
	logic write_edge_fall = 1'b0;
	logic read_edge_fall = 1'b0;
	logic write_en = 1'b0;
	logic [5:0] write_word_select = '0;
	logic [5:0] read_word_select = '0;
	logic [7:0] write_data_in = '0;
	logic [7:0] read_data;
	logic [7:0] m [32];
	logic [7:0] exp_q [$];
	wire logic write_clk;
	wire logic read_clk;
	int n_fail = 0;
	int cmp_count = 0;
	event show;
	always #4 clock = ~clock;
	dps_fabric fab (.clock(clock), .write_edge_fall(write_edge_fall),
		.read_edge_fall(read_edge_fall), .write_clk(write_clk),
		.read_clk(read_clk));
	dps_sram_block dut (.clock(clock), .rst(rst), .byte_mode(byte_mode),
		.read_async(read_async), .write_clk(write_clk),
		.write_edge_fall(write_edge_fall), .write_en(write_en),
		.write_word_select(write_word_select),
		.write_data_in(write_data_in), .read_clk(read_clk),
		.read_edge_fall(read_edge_fall),
		.read_word_select(read_word_select), .read_data(read_data));
	// expected read: nibble mode zero-extends the selected lane
	function automatic logic [7:0] ex(input logic [5:0] a);
		logic [7:0] w;
		w = m[a[4:0]];
		if (byte_mode) return w;
		return a[5] ? {4'h0, w[7:4]} : {4'h0, w[3:0]};
	endfunction : ex
	// one write and/or read; expectation noted before the edge
	task automatic acc(input logic w, r, input logic [5:0] wa, ra,
		input logic [7:0] d, input logic en);
		write_word_select = wa;
		write_data_in = d;
		write_en = en & w;
		read_word_select = ra;
		if (r) exp_q.push_back(ex(ra));
		fab.strobe(w, r & ~read_async);
		write_en = 1'b0;
		write_data_in = ~d;
		if (w && en) m[wa[4:0]] = byte_mode ? d : wa[5] ?
			{d[3:0], m[wa[4:0]][3:0]} : {m[wa[4:0]][7:4], d[3:0]};
		#1;
		if (r) ->show;
		@(posedge clock);
		#1;
	endtask : acc
	// watcher: oldest note against what the port shows
	always @(show) begin
		cmp_count++;
		if (read_data !== exp_q[0]) begin
			n_fail++;
			$display("unexpected read_data exp %h got %h", exp_q[0], read_data);
		end
		void'(exp_q.pop_front());
	end
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : finish_test
	// about 920 cycles expected; generous margin
	initial begin
		repeat (6000) @(posedge clock);
		n_fail++;
		finish_test();
	end
	initial begin
		logic [5:0] a;
		void'($urandom(94));
		repeat (2) @(posedge clock);
		#1;
		rst = 1'b0;
		repeat (2) @(posedge clock);
		#1;
		// polarity moves a cycle before the strobe, else no edge is seen
		for (int i = 0; i < 64; i++) begin
			write_edge_fall = i[0];
			@(posedge clock);
			#1;
			acc(1, 0, i[5:0], 0, 8'($urandom), 1);
		end
		for (int i = 0; i < 64; i++) begin
			read_edge_fall = ~i[0];
			@(posedge clock);
			#1;
			acc(0, 1, 0, i[5:0], 0, 0);
		end
		$display("test nibble fill done");
		read_async = 1'b1;
		repeat (8) acc(0, 1, 0, 6'($urandom), 0, 0);
		read_async = 1'b0;
		acc(1, 1, 6'h05, 6'h05, 8'h5a, 0);
		acc(1, 1, 6'h25, 6'h05, 8'($urandom), 1);
		acc(1, 1, 6'h06, 6'h25, 8'($urandom), 1);
		$display("test enable and concurrency done");
		byte_mode = 1'b1;
		for (int i = 0; i < 8; i++) begin
			a = 6'($urandom);
			acc(1, 0, a, 0, 8'($urandom), 1);
			read_async = i[0];
			acc(0, 1, 0, a ^ 6'h20, 0, 0);
		end
		read_async = 1'b0;
		acc(1, 1, a, a, 8'($urandom), 1);
		$display("test byte alias done");
		rst = 1'b1;
		@(posedge clock);
		#1;
		exp_q.push_back(DPS_RD_DATA_RST);
		->show;
		#1;
		rst = 1'b0;
		repeat (2) @(posedge clock);
		#1;
		acc(0, 1, 0, a, 0, 0);
		$display("test mid reset done");
		finish_test();
	end
endmodule : dps_sram_block_bench
`default_nettype wire
